// *** prs_map.svh ***
// Widths, reset values and timing counts for the reset and interrupt block
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH

// Clock rate and least global power-on reset hold time
`define PRS_CLK_KHZ      40000
`define PRS_POR_MIN_MS   2
`define PRS_POR_MIN_CYC  (`PRS_POR_MIN_MS * `PRS_CLK_KHZ)
`define PRS_HOLD_W       17

// Widths of the retained and reset-domain fields
`define PRS_CTX_W        8
`define PRS_IRQ_W        4

// Reset values
`define PRS_PM_CTX_RST   8'h00
`define PRS_VEND_RST     8'h00
`define PRS_MASK_RST     4'h0
`define PRS_HOLD_RST     17'h0_0000

`endif

// *** prs_pkg.sv ***
// Types shared by the reset and interrupt block
`include "prs_map.svh"

package prs_pkg;

   typedef enum logic [1:0] {
      ST_GLOBAL = 2'b00,
      ST_BUS    = 2'b01,
      ST_RUN    = 2'b10
   } prs_state_t;

   typedef struct packed {
      prs_state_t                st;
      logic [`PRS_HOLD_W-1:0]    hold_cnt;
      logic                      por_short;
      logic                      card_mode;
      logic [`PRS_CTX_W-1:0]     pm_ctx;
      logic [`PRS_CTX_W-1:0]     vend;
      logic [`PRS_IRQ_W-1:0]     mask;
      logic                      int_out;
      logic                      int_oe_n;
      logic                      active;
   } prs_top_t;

   typedef struct packed {
      logic [`PRS_IRQ_W-1:0]     pending;
      logic                      any;
   } prs_irq_t;

endpackage

// *** prs_irq_if.sv ***
// Carrier between the reset sequencer and the interrupt collector
`timescale 1ns/10ps
`default_nettype none
`include "prs_map.svh"

interface prs_irq_if;
   logic                   run;
   logic [`PRS_IRQ_W-1:0]  set;
   logic [`PRS_IRQ_W-1:0]  clear;
   logic [`PRS_IRQ_W-1:0]  mask;
   logic [`PRS_IRQ_W-1:0]  pending;
   logic                   any;

   modport gen (input run, input set, input clear, input mask,
                output pending, output any);
   modport ctl (output run, output set, output clear, output mask,
                input pending, input any);
endinterface

`default_nettype wire

// *** prs_irq_gen.sv ***
// Sticky interrupt collector with mask gating
`timescale 1ns/10ps
`default_nettype none
`include "prs_map.svh"

module prs_irq_gen
(
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  srst,
   // Link to the sequencer
   prs_irq_if.gen     irq
);

   prs_pkg::prs_irq_t s_r;
   prs_pkg::prs_irq_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (!irq.run)
      begin
         // Nonfunctional in either reset: nothing pends
         s_nxt.pending = '0;
         s_nxt.any     = 1'b0;
      end
      else
      begin
         // Set beats a clear in the same cycle
         s_nxt.pending = (s_r.pending & ~irq.clear) | irq.set;
         s_nxt.any     = |(s_nxt.pending & irq.mask);
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign irq.pending = s_r.pending;
   assign irq.any     = s_r.any;

endmodule // prs_irq_gen

`default_nettype wire

// *** prs_reset_ctrl.sv ***
// Reset sequencing and host interrupt pin of the bus-attached controller
//
// Behaviour
// - Global reset restores every register to default
// - Global reset: no function, outputs floated
// - Bus reset spares power-management and vendor bits
// - Bus reset: nonfunctional, all outputs floated
// - All bus signals sampled on rising clock
// - Unmasked pending interrupts drive dedicated interrupt output
// - Strap low: interrupt pin acts as card interrupt
`timescale 1ns/10ps
`default_nettype none
`include "prs_map.svh"

module prs_reset_ctrl
#(
   parameter int POR_MIN_CYC = `PRS_POR_MIN_CYC
)
(
   // Clock and local reset
   input  wire logic                   clock,
   input  wire logic                   srst,
   // System reset and strap pins
   input  wire logic                   global_rst_n,
   input  wire logic                   bus_rst_n,
   input  wire logic                   pc_card_mode_strap,
   // Interrupt events from the controller core
   input  wire logic [`PRS_IRQ_W-1:0]  irq_event,
   input  wire logic [`PRS_IRQ_W-1:0]  irq_clear,
   input  wire logic                   mask_wr,
   input  wire logic [`PRS_IRQ_W-1:0]  mask_wdata,
   // Retained context written by power-on software
   input  wire logic                   pm_ctx_wr,
   input  wire logic [`PRS_CTX_W-1:0]  pm_ctx_wdata,
   input  wire logic                   vend_wr,
   input  wire logic [`PRS_CTX_W-1:0]  vend_wdata,
   // Host interrupt pin
   output logic                        host_interrupt_out,
   output logic                        host_interrupt_oe_n,
   // State seen by the core
   output logic                        dev_active,
   output logic                        card_mode,
   output logic                        por_short,
   output logic [`PRS_CTX_W-1:0]       pm_ctx,
   output logic [`PRS_CTX_W-1:0]       vend_bits,
   output logic [`PRS_IRQ_W-1:0]       irq_mask,
   output logic [`PRS_IRQ_W-1:0]       irq_pending
);

   localparam logic [`PRS_HOLD_W-1:0] HOLD_MIN =
      `PRS_HOLD_W'(POR_MIN_CYC);

   prs_pkg::prs_top_t s_r;
   prs_pkg::prs_top_t s_nxt;

   prs_irq_if irq ();

   prs_irq_gen u_irq
   (
      .clock (clock),
      .srst  (srst),
      .irq   (irq.gen)
   );

   // Core runs only outside both resets
   assign irq.run   = s_r.active;
   assign irq.set   = irq_event;
   assign irq.clear = irq_clear;
   assign irq.mask  = s_r.mask;

   always_comb
   begin
      s_nxt = s_r;
      case (s_r.st)
         prs_pkg::ST_GLOBAL:
         begin
            // Full default, retained bits included
            s_nxt.pm_ctx   = `PRS_PM_CTX_RST;
            s_nxt.vend     = `PRS_VEND_RST;
            s_nxt.mask     = `PRS_MASK_RST;
            s_nxt.card_mode = 1'b0;
            s_nxt.por_short = 1'b0;
            s_nxt.int_out  = 1'b1;
            s_nxt.int_oe_n = 1'b1;
            s_nxt.active   = 1'b0;
            if (s_r.hold_cnt != HOLD_MIN)
               s_nxt.hold_cnt = s_r.hold_cnt + `PRS_HOLD_W'(1);
            if (global_rst_n)
            begin
               // Flag a global reset held shorter than the minimum
               s_nxt.por_short = (s_r.hold_cnt != HOLD_MIN);
               // Strap caught at the release, clocked
               s_nxt.card_mode = ~pc_card_mode_strap;
               s_nxt.hold_cnt  = `PRS_HOLD_RST;
               s_nxt.st        = bus_rst_n ? prs_pkg::ST_RUN
                                           : prs_pkg::ST_BUS;
            end
         end
         prs_pkg::ST_BUS:
         begin
            // Reset domain only; retained bits kept, writes refused
            s_nxt.mask     = `PRS_MASK_RST;
            s_nxt.int_out  = 1'b1;
            s_nxt.int_oe_n = 1'b1;
            s_nxt.active   = 1'b0;
            if (bus_rst_n)
               s_nxt.st = prs_pkg::ST_RUN;
         end
         prs_pkg::ST_RUN:
         begin
            s_nxt.active = 1'b1;
            if (mask_wr)
               s_nxt.mask = mask_wdata;
            if (pm_ctx_wr)
               s_nxt.pm_ctx = pm_ctx_wdata;
            if (vend_wr)
               s_nxt.vend = vend_wdata;
            if (s_r.card_mode)
            begin
               // Card interrupt: driven both ways, low when pending
               s_nxt.int_out  = ~irq.any;
               s_nxt.int_oe_n = 1'b0;
            end
            else
            begin
               // Open-drain: pull low only while pending
               s_nxt.int_out  = 1'b0;
               s_nxt.int_oe_n = ~irq.any;
            end
            if (!bus_rst_n)
            begin
               s_nxt.active   = 1'b0;
               s_nxt.int_out  = 1'b1;
               s_nxt.int_oe_n = 1'b1;
               s_nxt.st       = prs_pkg::ST_BUS;
               // Writes in the entry cycle are refused too
               s_nxt.mask     = `PRS_MASK_RST;
               s_nxt.pm_ctx   = s_r.pm_ctx;
               s_nxt.vend     = s_r.vend;
            end
         end
         default:
         begin
            s_nxt.st       = prs_pkg::ST_GLOBAL;
            s_nxt.active   = 1'b0;
            s_nxt.int_out  = 1'b1;
            s_nxt.int_oe_n = 1'b1;
         end
      endcase
      // Global reset overrides the bus reset at any time
      if (!global_rst_n)
      begin
         if (s_r.st != prs_pkg::ST_GLOBAL)
            s_nxt.hold_cnt = `PRS_HOLD_RST;
         s_nxt.st       = prs_pkg::ST_GLOBAL;
         s_nxt.active   = 1'b0;
         // Defaults from the first reset edge, not one later
         s_nxt.pm_ctx    = `PRS_PM_CTX_RST;
         s_nxt.vend      = `PRS_VEND_RST;
         s_nxt.mask      = `PRS_MASK_RST;
         s_nxt.card_mode = 1'b0;
         s_nxt.por_short = 1'b0;
         s_nxt.int_out  = 1'b1;
         s_nxt.int_oe_n = 1'b1;
      end
   end

   // All pins sampled on the rising clock edge
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_r           <= '0;
         s_r.st        <= prs_pkg::ST_GLOBAL;
         s_r.pm_ctx    <= `PRS_PM_CTX_RST;
         s_r.vend      <= `PRS_VEND_RST;
         s_r.mask      <= `PRS_MASK_RST;
         s_r.hold_cnt  <= `PRS_HOLD_RST;
         s_r.int_out   <= 1'b1;
         s_r.int_oe_n  <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign host_interrupt_out  = s_r.int_out;
   assign host_interrupt_oe_n = s_r.int_oe_n;
   assign dev_active          = s_r.active;
   assign card_mode           = s_r.card_mode;
   assign por_short           = s_r.por_short;
   assign pm_ctx              = s_r.pm_ctx;
   assign vend_bits           = s_r.vend;
   assign irq_mask            = s_r.mask;
   assign irq_pending         = irq.pending;

endmodule // prs_reset_ctrl

`default_nettype wire

// *** prs_reset_chk.sv ***
// Assertions on the reset sequencer and host interrupt pin
`timescale 1ns/10ps
`default_nettype none
module prs_reset_chk
(
   // Clock, resets and strap
   input wire logic       clock,
   input wire logic       srst,
   input wire logic       global_rst_n,
   input wire logic       bus_rst_n,
   input wire logic       pc_card_mode_strap,
   // Block outputs
   input wire logic       host_interrupt_out,
   input wire logic       host_interrupt_oe_n,
   input wire logic       dev_active,
   input wire logic       card_mode,
   input wire logic [7:0] pm_ctx,
   input wire logic [3:0] irq_mask,
   input wire logic [3:0] irq_pending
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   property p_por_float;
      !global_rst_n |=> host_interrupt_oe_n && !dev_active;
   endproperty
   a_por_float: assert property (p_por_float)
      else $error("pin driven in power reset");
   property p_por_clr;
      !global_rst_n |=> pm_ctx == 8'h00 && irq_mask == 4'h0 && !card_mode;
   endproperty
   a_por_clr: assert property (p_por_clr)
      else $error("register kept in power reset");
   property p_bus_float;
      !bus_rst_n |=> host_interrupt_oe_n && !dev_active;
   endproperty
   a_bus_float: assert property (p_bus_float)
      else $error("pin driven in bus reset");
   property p_bus_keep;
      !bus_rst_n && global_rst_n |=> $stable(pm_ctx);
   endproperty
   a_bus_keep: assert property (p_bus_keep)
      else $error("context lost in bus reset");
   property p_idle_pend;
      !dev_active |=> irq_pending == 4'h0;
   endproperty
   a_idle_pend: assert property (p_idle_pend)
      else $error("pending while inactive");
   property p_pci_pin;
      dev_active[*3] ##0 !card_mode |-> !host_interrupt_out
         && host_interrupt_oe_n ==
            !(|($past(irq_pending) & $past(irq_mask, 2)));
   endproperty
   a_pci_pin: assert property (p_pci_pin)
      else $error("bus interrupt pin wrong");
   property p_card_pin;
      dev_active[*3] ##0 card_mode |-> !host_interrupt_oe_n
         && host_interrupt_out ==
            !(|($past(irq_pending) & $past(irq_mask, 2)));
   endproperty
   a_card_pin: assert property (p_card_pin)
      else $error("card interrupt pin wrong");
   property p_strap;
      !global_rst_n ##1 global_rst_n |=>
         card_mode == !$past(pc_card_mode_strap);
   endproperty
   a_strap: assert property (p_strap)
      else $error("strap not latched");
   c_pci: cover property (!card_mode && !host_interrupt_oe_n);
   c_card: cover property (card_mode && !host_interrupt_out);
   c_bus: cover property (!bus_rst_n && global_rst_n);
endmodule // prs_reset_chk
bind prs_reset_ctrl prs_reset_chk chk_u (.clock, .srst, .global_rst_n,
   .bus_rst_n, .pc_card_mode_strap, .host_interrupt_out,
   .host_interrupt_oe_n, .dev_active, .card_mode, .pm_ctx, .irq_mask,
   .irq_pending);
`default_nettype wire

// *** prs_host_model.sv ***
// Host system model: power-on and bus reset sources
`timescale 1ns/10ps
`default_nettype none
module prs_host_model
#(
   parameter int POR_CYC = 40
)
(
   // Clock and requests
   input  wire logic clock,
   input  wire logic por_req,
   input  wire logic bus_req,
   // Reset pins
   output var logic  global_rst_n,
   output var logic  bus_rst_n
);
   int cnt = POR_CYC;
   // Power reset on power-up and on each por_req, held a full count
   always @(posedge clock)
   begin
      if (por_req)
         cnt <= POR_CYC;
      else if (cnt != 0)
         cnt <= cnt - 1;
      global_rst_n <= (cnt == 0) && !por_req;
      bus_rst_n <= !bus_req;
   end
endmodule // prs_host_model
`default_nettype wire

// *** testbench.sv ***
// Testbench for the reset sequencer and host interrupt pin
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
   failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
   logic       clock = 1'b0;
   logic       srst = 1'b1;
   logic       pc_card_mode_strap = 1'b1;
   logic       por_req = 1'b0;
   logic       bus_req = 1'b0;
   logic       mask_wr = 1'b0;
   logic       pm_ctx_wr = 1'b0;
   logic       vend_wr = 1'b0;
   logic [3:0] irq_event = 4'h0;
   logic [3:0] irq_clear = 4'h0;
   logic [3:0] mask_wdata = 4'h0;
   logic [7:0] pm_ctx_wdata = 8'h00;
   logic [7:0] vend_wdata = 8'h00;
   wire        global_rst_n, bus_rst_n, host_interrupt_out;
   wire        host_interrupt_oe_n, dev_active, card_mode, por_short;
   wire  [7:0] pm_ctx, vend_bits;
   wire  [3:0] irq_mask, irq_pending;
   int         failures = 0;
   int         check_count = 0;
   always #12.5 clock = ~clock;
   prs_host_model #(.POR_CYC(40)) host_u (.clock, .por_req, .bus_req,
      .global_rst_n, .bus_rst_n);
   prs_reset_ctrl #(.POR_MIN_CYC(20)) dut_u (.clock, .srst, .global_rst_n,
      .bus_rst_n, .pc_card_mode_strap, .irq_event, .irq_clear, .mask_wr,
      .mask_wdata, .pm_ctx_wr, .pm_ctx_wdata, .vend_wr, .vend_wdata,
      .host_interrupt_out, .host_interrupt_oe_n, .dev_active, .card_mode,
      .por_short, .pm_ctx, .vend_bits, .irq_mask, .irq_pending);
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task wr(input logic [3:0] m, input logic [7:0] p, input logic [7:0] v);
      cyc(1);
      {mask_wr, pm_ctx_wr, vend_wr} <= 3'b111;
      mask_wdata <= m;
      pm_ctx_wdata <= p;
      vend_wdata <= v;
      cyc(1);
      {mask_wr, pm_ctx_wr, vend_wr} <= 3'b000;
   endtask
   // Event or clear for one cycle, then wait until the pin follows
   task ev(input logic [3:0] e, input logic [3:0] c);
      cyc(1);
      irq_event <= e;
      irq_clear <= c;
      cyc(1);
      irq_event <= 4'h0;
      irq_clear <= 4'h0;
      cyc(2);
      #1;
   endtask
   task pin(input logic on, input logic cm);
      `CHK({host_interrupt_out, host_interrupt_oe_n}, on ? 2'b00 : {cm, !cm})
   endtask
   task wait_act;
      repeat (60) if (dev_active !== 1'b1) cyc(1);
      #1;
      `CHK(dev_active, 1'b1)
   endtask
   task t_por;
      cyc(2);
      #1;
      `CHK({host_interrupt_oe_n, dev_active}, 2'b10)
      wait_act();
      `CHK({card_mode, por_short}, 2'b00)
      `CHK({pm_ctx, vend_bits, irq_mask}, 20'h0_0000)
   endtask
   task t_irq(input logic cm);
      wr(4'h2, 8'hA5, 8'h5A);
      ev(4'h1, 4'h0);
      `CHK(irq_pending, 4'h1)
      pin(1'b0, cm);
      ev(4'h2, 4'h0);
      `CHK(irq_pending, 4'h3)
      pin(1'b1, cm);
      ev(4'h0, 4'h2);
      pin(1'b0, cm);
   endtask
   task t_bus;
      ev(4'h2, 4'h0);
      cyc(1);
      bus_req <= 1'b1;
      cyc(4);
      #1;
      `CHK({host_interrupt_oe_n, dev_active}, 2'b10)
      `CHK({pm_ctx, vend_bits}, 16'hA55A)
      `CHK({irq_mask, irq_pending}, 8'h00)
      cyc(1);
      pm_ctx_wr <= 1'b1;
      pm_ctx_wdata <= 8'hFF;
      cyc(1);
      pm_ctx_wr <= 1'b0;
      bus_req <= 1'b0;
      cyc(1);
      #1;
      `CHK(pm_ctx, 8'hA5)
      wait_act();
   endtask
   task t_card;
      cyc(1);
      pc_card_mode_strap <= 1'b0;
      por_req <= 1'b1;
      cyc(1);
      por_req <= 1'b0;
      wr(4'hF, 8'h11, 8'h22);
      #1;
      `CHK(host_interrupt_oe_n, 1'b1)
      wait_act();
      `CHK({pm_ctx, vend_bits, irq_mask}, 20'h0_0000)
      `CHK(card_mode, 1'b1)
      t_irq(1'b1);
   endtask
   task close_out;
      $display("mismatches %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(6);
      srst <= 1'b0;
      t_por();
      t_irq(1'b0);
      t_bus();
      t_card();
      close_out();
   end
   initial
   begin
      #100us;
      failures++;
      close_out();
   end
endmodule // testbench
`default_nettype wire
